/* core/psl_pkg.sv */
// Package for the strap, LED, general pin and interrupt pin block.
// Assumes a single 40 MHz clock and a synchronous active-high reset.
package psl_pkg;

  // ----------------------------------------
  // Register indices (word addressed, 16-bit data)
  // ----------------------------------------
  localparam logic [4:0] REG_CONTROL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h01;
  localparam logic [4:0] REG_VENDOR = 5'h10;
  localparam logic [4:0] REG_IRQ_CTRL = 5'h11;
  localparam logic [4:0] REG_PHONE_IRQ = 5'h13;
  localparam logic [4:0] REG_EVENTS = 5'h14;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTL_SPEED_BIT = 13;
  localparam int CTL_DUPLEX_BIT = 8;
  localparam int STS_ABIL_LO = 11;
  localparam int VND_PIN0_DIR = 6;
  localparam int VND_PIN0_LVL = 7;
  localparam int VND_PIN1_DIR = 8;
  localparam int VND_PIN1_LVL = 9;
  localparam int VND_PIN0_OUT = 10;
  localparam int VND_PIN1_OUT = 11;
  localparam int VND_IRQ_POL = 14;
  localparam int IRQ_ENABLE_LO = 8;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] VENDOR_RESET = 16'h0141;
  localparam logic [15:0] IRQ_CTRL_RESET = 16'h0000;
  localparam logic [15:0] PHONE_IRQ_RESET = 16'h0000;
  localparam int SYNC_STAGES = 3;

  // Decoded strap abilities
  typedef struct packed {
    logic half;
    logic full;
    logic phone;
  } psl_abil_t;

endpackage : psl_pkg

/* core/psl_strap_led.sv */
// Contract
// - Decode three-bit strap into advertised abilities
// - Mirror abilities into control and status
// - Port strap high selects nibble port
// - Port strap low: serial in phoneline
// - LED outputs are active low
// - Link LED lit while link up
// - Transmit LED lit during transmission
// - Receive LED lit during reception
// - Collision LED lit, dark in full duplex outside phoneline
// - Power LED shows phoneline high power
// - 10BASE-T LED lit with link up outside phoneline, dark during negotiation
// - Duplex/speed LED by phoneline enable
// - Phoneline LED follows phoneline enable
// - Pin zero direction bit 6, level 7
// - Pin one direction bit 8, level 9
// - Pins reset as inputs with pull-down
// - Interrupt pin released when idle
// - Interrupt driven to selected polarity
// - Interrupt only from enabled events
//
// Strap decode, MAC port select, LED drivers, general pins and interrupt pin.
// Assumes pins and status come from outside the clock domain; register port
// is driven by same-clock management logic.
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/10ps
module psl_strap_led (
  input wire logic clk, // 40 MHz block clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [4:0] regAddr, // Register index
  input wire logic [15:0] regWrData, // Write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  output logic [15:0] regRdData, // Read data, cycle after strobe
  input wire logic [2:0] technology_strap, // Technology strap pins
  input wire logic portSelStrap, // High selects nibble MAC port
  input wire logic phoneline_enable, // Phoneline operating mode
  input wire logic linkUp, // Link status
  input wire logic txActive, // Transmission in progress
  input wire logic rxActive, // Reception in progress
  input wire logic collision, // Collision seen
  input wire logic fullDuplex, // Full duplex operation
  input wire logic highPower, // Phoneline high power mode
  input wire logic highSpeed, // Phoneline high speed mode
  input wire logic anegBusy, // Auto-negotiation in progress
  input wire logic [7:0] eventIn, // Ten-base event pulses
  input wire logic [7:0] phoneEventIn, // Phoneline event pulses
  output logic nibblePortSel, // High: nibble port, low: serial_mac_port
  output logic link_led, // Active low
  output logic tx_activity_led, // Active low
  output logic rx_activity_led, // Active low
  output logic collision_led, // Active low
  output logic high_power_led, // Active low
  output logic tenbase_led, // Active low
  output logic duplex_speed_led, // Active low
  output logic phoneline_mode_led, // Active low
  input wire logic general_pin_zero_i, // Pin zero level in
  output logic general_pin_zero_o, // Pin zero drive value
  output logic general_pin_zero_oe, // Pin zero drive enable
  output logic general_pin_zero_pd, // Pin zero weak pull-down on
  input wire logic general_pin_one_i, // Pin one level in
  output logic general_pin_one_o, // Pin one drive value
  output logic general_pin_one_oe, // Pin one drive enable
  output logic general_pin_one_pd, // Pin one weak pull-down on
  output logic irq_output_o, // Interrupt drive value
  output logic irq_output_oe // Interrupt drive enable
);
  import psl_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int NSYNC = 14;
  psl_sync_if #(.W(NSYNC)) syncBus ();
  assign syncBus.raw = {technology_strap, portSelStrap, phoneline_enable, linkUp,
    txActive, rxActive, collision, fullDuplex, highPower, highSpeed,
    general_pin_zero_i, general_pin_one_i};

  psl_sync #(.W(NSYNC)) uSync (
    .clk(clk),
    .rst(rst),
    .pins(syncBus.owner)
  );

  logic [2:0] techS;
  logic portS, phoneS, linkS, txS, rxS, colS, fdxS, hpwS, hspS, pin0S, pin1S;
  assign {techS, portS, phoneS, linkS, txS, rxS, colS, fdxS, hpwS, hspS,
    pin0S, pin1S} = syncBus.stable;

  // Negotiation flag is a level; a three-flop chain delays it, one cycle less than the synchronised group
  logic anegS;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] vendor;
    logic [15:0] irqCtrl;
    logic [15:0] phoneIrq;
    logic [7:0] evSticky;
    logic [7:0] phoneSticky;
    logic [15:0] rdData;
    logic aneg1;
    logic aneg2;
    logic aneg3;
    logic portSel;
    logic [7:0] leds;
    logic pin0O, pin0Oe, pin1O, pin1Oe;
    logic irqO, irqOe;
  } psl_state_t;

  psl_state_t state_r;
  psl_state_t state_nxt;
  psl_abil_t abil;
  logic [15:0] ctrlView;
  logic [15:0] statusView;
  logic irqPending;

  assign anegS = state_r.aneg3;

  // ----------------------------------------
  // Strap decode
  // ----------------------------------------
  // strap ability table
  always_comb
  begin
    case (techS)
      3'h0: abil = '{half: 1'b1, full: 1'b1, phone: 1'b0};
      3'h1: abil = '{half: 1'b1, full: 1'b0, phone: 1'b0};
      3'h3: abil = '{half: 1'b1, full: 1'b0, phone: 1'b0};
      3'h4: abil = '{half: 1'b0, full: 1'b0, phone: 1'b1};
      3'h5: abil = '{half: 1'b0, full: 1'b1, phone: 1'b0};
      3'h7: abil = '{half: 1'b1, full: 1'b1, phone: 1'b1};
      // Reserved codes advertise nothing
      default: abil = '{half: 1'b0, full: 1'b0, phone: 1'b0};
    endcase
  end

  always_comb
  begin
    ctrlView = 16'h0000;
    ctrlView[CTL_SPEED_BIT] = abil.half | abil.full;
    ctrlView[CTL_DUPLEX_BIT] = abil.full & ~abil.half;
    statusView = 16'h0000;
    statusView[STS_ABIL_LO +: 4] = {1'b0, 1'b0, abil.full, abil.half} |
      {abil.phone, 3'h0};
  end

  assign irqPending = |(state_r.evSticky & state_r.irqCtrl[IRQ_ENABLE_LO +: 8])
    | |(state_r.phoneSticky & state_r.phoneIrq[IRQ_ENABLE_LO +: 8]);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.aneg1 = anegBusy;
    state_nxt.aneg2 = state_r.aneg1;
    state_nxt.aneg3 = state_r.aneg2;

    // Register writes
    if (regWr)
    begin
      case (regAddr)
        REG_VENDOR: state_nxt.vendor = regWrData;
        REG_IRQ_CTRL: state_nxt.irqCtrl = regWrData;
        REG_PHONE_IRQ: state_nxt.phoneIrq = regWrData;
        default: state_nxt.vendor = state_r.vendor;
      endcase
    end

    // Sticky events: reading the event register clears, a new event wins
    if (regRd && regAddr == REG_EVENTS)
    begin
      state_nxt.evSticky = 8'h00;
      state_nxt.phoneSticky = 8'h00;
    end
    state_nxt.evSticky = state_nxt.evSticky | eventIn;
    state_nxt.phoneSticky = state_nxt.phoneSticky | phoneEventIn;

    // level bits show pin as seen
    state_nxt.vendor[VND_PIN0_LVL] = pin0S;
    state_nxt.vendor[VND_PIN1_LVL] = pin1S;

    // Register reads
    state_nxt.rdData = 16'h0000;
    if (regRd)
    begin
      case (regAddr)
        REG_CONTROL: state_nxt.rdData = ctrlView;
        REG_STATUS: state_nxt.rdData = statusView;
        REG_VENDOR: state_nxt.rdData = state_r.vendor;
        REG_IRQ_CTRL: state_nxt.rdData = state_r.irqCtrl;
        REG_PHONE_IRQ: state_nxt.rdData = state_r.phoneIrq;
        REG_EVENTS: state_nxt.rdData = {state_r.phoneSticky, state_r.evSticky};
        default: state_nxt.rdData = 16'h0000;
      endcase
    end

    state_nxt.portSel = portS | ~phoneS;

    // lit LED drives low; order link,tx,rx,col,pwr,ten,dspd,phone
    state_nxt.leds[7] = ~linkS;
    state_nxt.leds[6] = ~txS;
    state_nxt.leds[5] = ~rxS;
    state_nxt.leds[4] = ~(colS & (phoneS | ~fdxS));
    state_nxt.leds[3] = ~(hpwS & phoneS);
    state_nxt.leds[2] = ~(linkS & ~phoneS & ~anegS);
    state_nxt.leds[1] = ~(phoneS ? hspS : fdxS);
    state_nxt.leds[0] = ~phoneS;

    state_nxt.pin0Oe = ~state_r.vendor[VND_PIN0_DIR];
    state_nxt.pin0O = state_r.vendor[VND_PIN0_OUT];
    state_nxt.pin1Oe = ~state_r.vendor[VND_PIN1_DIR];
    state_nxt.pin1O = state_r.vendor[VND_PIN1_OUT];

    // drive only while pending, at chosen level
    state_nxt.irqOe = irqPending;
    state_nxt.irqO = state_r.vendor[VND_IRQ_POL];
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= '0;
      // both pins come up as inputs
      state_r.vendor <= VENDOR_RESET;
      state_r.irqCtrl <= IRQ_CTRL_RESET;
      state_r.phoneIrq <= PHONE_IRQ_RESET;
      state_r.leds <= 8'hFF;
      state_r.portSel <= 1'b1;
    end
    else
      state_r <= state_nxt;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign regRdData = state_r.rdData;
  assign nibblePortSel = state_r.portSel;
  assign {link_led, tx_activity_led, rx_activity_led, collision_led, high_power_led,
    tenbase_led, duplex_speed_led, phoneline_mode_led} = state_r.leds;
  assign general_pin_zero_o = state_r.pin0O;
  assign general_pin_zero_oe = state_r.pin0Oe;
  assign general_pin_zero_pd = state_r.vendor[VND_PIN0_DIR];
  assign general_pin_one_o = state_r.pin1O;
  assign general_pin_one_oe = state_r.pin1Oe;
  assign general_pin_one_pd = state_r.vendor[VND_PIN1_DIR];
  assign irq_output_o = state_r.irqO;
  assign irq_output_oe = state_r.irqOe;
endmodule : psl_strap_led

/* core/psl_sync.sv */
// Three-stage pin synchroniser; a change is accepted once stages two and three agree.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/10ps
module psl_sync #(
  parameter int W = 1
) (
  input wire logic clk, // Block clock
  input wire logic rst, // Synchronous reset
  psl_sync_if.owner pins // Raw in, stable out
);
  import psl_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } psl_sync_t;

  psl_sync_t state_r;
  psl_sync_t state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    state_nxt.s1 = pins.raw;
    state_nxt.s2 = state_r.s1;
    state_nxt.s3 = state_r.s2;
    // Only bits on which stages two and three agree move
    state_nxt.out = (state_r.s2 & ~(state_r.s2 ^ state_r.s3))
      | (state_r.out & (state_r.s2 ^ state_r.s3));
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign pins.stable = state_r.out;
endmodule : psl_sync

/* core/psl_sync_if.sv */
// Interface carrying one synchronised pin group between modules.
// Assumes both ends share the block clock.
`timescale 1ns/10ps
interface psl_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] stable;
  modport owner (input raw, output stable);
  modport user (output raw, input stable);
endinterface : psl_sync_if

/* testbench/psl_pin_model.sv */
// Far side: general pin wires and the interrupt line seen by the MAC.
// Assumes an enable high means the block drives that wire.
`timescale 1ns/10ps
module psl_pin_model (
  input wire logic clk, // Clock
  input wire logic [1:0] oe, // Block enables
  input wire logic [1:0] o, // Block values
  input wire logic [1:0] pd, // Pull-downs
  input wire logic [1:0] drv, // Outside drive on
  input wire logic [1:0] val, // Outside value
  input wire logic irqOe, // Irq enable
  input wire logic irqO, // Irq value
  output logic [1:0] pin, // Pin levels
  output logic irqWire // Irq line
);
  logic [1:0] last;
  logic lastIrq;
  // Floating lines wander so a stale value cannot pass
  always_comb
  begin
    for (int k = 0; k < 2; k++)
      pin[k] = oe[k] ? o[k] : drv[k] ? val[k] : pd[k] ? 1'b0 : ~last[k];
    irqWire = irqOe ? irqO : ~lastIrq;
  end
  always_ff @(posedge clk)
  begin
    last <= pin;
    lastIrq <= irqWire;
  end
endmodule : psl_pin_model

/* testbench/psl_strap_led_properties.sv */
// Checker bound onto the strap, LED, pin and interrupt block.
// Assumes six steady samples cover synchroniser and output flop.
`timescale 1ns/10ps
module psl_strap_led_properties (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic regWr, // Write
  input wire logic portSelStrap, // Strap
  input wire logic phoneline_enable, // Mode
  input wire logic linkUp, // Link
  input wire logic txActive, // Tx
  input wire logic rxActive, // Rx
  input wire logic fullDuplex, // Duplex
  input wire logic anegBusy, // Negotiation
  input wire logic [7:0] eventIn, // Events
  input wire logic [7:0] phoneEventIn, // Events
  input wire logic nibblePortSel, // Port
  input wire logic link_led, // LED
  input wire logic tx_activity_led, // LED
  input wire logic rx_activity_led, // LED
  input wire logic collision_led, // LED
  input wire logic tenbase_led, // LED
  input wire logic phoneline_mode_led, // LED
  input wire logic general_pin_zero_oe, // Enable
  input wire logic general_pin_zero_pd, // Pull
  input wire logic general_pin_one_oe, // Enable
  input wire logic irq_output_oe // Enable
);
  logic cause;
  // A write may enable an event latched earlier
  assign cause = |eventIn || |phoneEventIn || regWr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // Sequences
  // ----
  sequence s_phone;
    phoneline_enable [*6];
  endsequence
  sequence s_serial;
    (!portSelStrap && phoneline_enable) [*6];
  endsequence
  a_link_led_lit: assert property (linkUp [*6] |=> !link_led)
    else $error("link LED not lit");
  a_link_led_dark: assert property (!linkUp [*6] |=> link_led)
    else $error("link LED not dark");
  a_tx_led_lit: assert property (txActive [*6] |=> !tx_activity_led)
    else $error("tx LED not lit");
  a_rx_led_dark: assert property (!rxActive [*6] |=> rx_activity_led)
    else $error("rx LED not dark");
  // Phoneline mode keeps collisions visible whatever the duplex input says
  a_col_full_dark: assert property ((fullDuplex && !phoneline_enable) [*6] |=> collision_led)
    else $error("collision LED lit in full duplex");
  a_ten_aneg_dark: assert property (anegBusy [*6] |=> tenbase_led)
    else $error("ten LED lit while negotiating");
  a_mode_led_lit: assert property (s_phone |=> !phoneline_mode_led)
    else $error("mode LED not lit");
  a_nibble_strap_hi: assert property (portSelStrap [*6] |=> nibblePortSel)
    else $error("nibble port not selected");
  a_serial_phone_sel: assert property (s_serial |=> !nibblePortSel)
    else $error("serial port not selected");
  a_pins_reset_in: assert property ($fell(rst) |->
    !general_pin_zero_oe && !general_pin_one_oe && general_pin_zero_pd)
    else $error("pins not inputs after reset");
  a_irq_from_cause: assert property ($rose(irq_output_oe) |->
    $past(cause, 1) || $past(cause, 2) || $past(cause, 3))
    else $error("interrupt without event");
endmodule : psl_strap_led_properties

bind psl_strap_led psl_strap_led_properties i_props (.clk(clk), .rst(rst), .regWr(regWr),
  .portSelStrap(portSelStrap), .phoneline_enable(phoneline_enable), .linkUp(linkUp),
  .txActive(txActive), .rxActive(rxActive), .fullDuplex(fullDuplex), .anegBusy(anegBusy),
  .eventIn(eventIn), .phoneEventIn(phoneEventIn), .nibblePortSel(nibblePortSel),
  .link_led(link_led), .tx_activity_led(tx_activity_led), .rx_activity_led(rx_activity_led),
  .collision_led(collision_led), .tenbase_led(tenbase_led),
  .phoneline_mode_led(phoneline_mode_led), .general_pin_zero_oe(general_pin_zero_oe),
  .general_pin_zero_pd(general_pin_zero_pd), .general_pin_one_oe(general_pin_one_oe),
  .irq_output_oe(irq_output_oe));

/* testbench/testbench.sv */
// Self-checking bench for the strap, LED, pin and interrupt block.
// Assumes tasks start just after a rising edge.
`timescale 1ns/10ps
module testbench;
  import psl_pkg::*;
  logic clk = 0, rst = 1, regWr = 0, regRd = 0;
  logic [4:0] regAddr = 5'h00;
  logic [15:0] regWrData = 16'h0000, regRdData, d;
  logic [2:0] technology_strap = 3'h0;
  logic [9:0] v = 10'h000;
  logic [7:0] eventIn = 8'h00, phoneEventIn = 8'h00, led;
  logic [1:0] oe, o, pd, pin, drv = 2'h0, val = 2'h0;
  logic nibblePortSel, irqO, irqOe, irqWire;
  int failures = 0, checked = 0;
  always #12.5 clk = ~clk;
  psl_strap_led i_psl_strap_led (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .technology_strap(technology_strap), .portSelStrap(v[9]), .phoneline_enable(v[8]),
    .linkUp(v[7]), .txActive(v[6]), .rxActive(v[5]), .collision(v[4]), .fullDuplex(v[3]),
    .highPower(v[2]), .highSpeed(v[1]), .anegBusy(v[0]), .eventIn(eventIn),
    .phoneEventIn(phoneEventIn), .nibblePortSel(nibblePortSel), .link_led(led[7]),
    .tx_activity_led(led[6]), .rx_activity_led(led[5]), .collision_led(led[4]),
    .high_power_led(led[3]), .tenbase_led(led[2]), .duplex_speed_led(led[1]),
    .phoneline_mode_led(led[0]), .general_pin_zero_i(pin[0]), .general_pin_zero_o(o[0]),
    .general_pin_zero_oe(oe[0]), .general_pin_zero_pd(pd[0]), .general_pin_one_i(pin[1]),
    .general_pin_one_o(o[1]), .general_pin_one_oe(oe[1]), .general_pin_one_pd(pd[1]),
    .irq_output_o(irqO), .irq_output_oe(irqOe));
  psl_pin_model i_psl_pin_model (.clk(clk), .oe(oe), .o(o), .pd(pd), .drv(drv), .val(val),
    .irqOe(irqOe), .irqO(irqO), .pin(pin), .irqWire(irqWire));
  // ----
  // Shared tasks
  // ----
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [4:0] a, input logic [15:0] w);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= w;
    idle(1);
    regWr <= 1'b0;
    idle(1);
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] q);
    regRd <= 1'b1;
    regAddr <= a;
    idle(1);
    regRd <= 1'b0;
    q = regRdData;
    idle(1);
  endtask : rd
  task automatic pulse(input logic [7:0] e, input logic [7:0] p);
    eventIn <= e;
    phoneEventIn <= p;
    idle(1);
    eventIn <= 8'h00;
    phoneEventIn <= 8'h00;
    idle(3);
  endtask : pulse
  task automatic report_and_stop;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    cmp("leds", 16'h00FF, led);
    cmp("pins", 16'h0003, {oe, pd});
    cmp("irq", 16'h0000, irqOe);
    rst <= 1'b0;
    rd(REG_VENDOR, d);
    cmp("dir", 16'h0140, d & 16'h0140);
  endtask : t_reset
  task automatic t_strap;
    logic h, f, p;
    for (int c = 0; c < 8; c++)
    begin
      technology_strap <= c[2:0];
      idle(8);
      h = c inside {0, 1, 3, 7};
      f = c inside {0, 5, 7};
      p = c inside {4, 7};
      rd(REG_CONTROL, d);
      cmp("ctl", {2'h0, h | f, 4'h0, f & !h, 8'h00}, d & 16'h2100);
      rd(REG_STATUS, d);
      cmp("sts", {1'h0, p, 1'h0, f, h, 11'h000}, d & 16'h5800);
    end
  endtask : t_strap
  task automatic t_leds;
    logic [9:0] tbl [7] = '{10'h0D0, 10'h2B8, 10'h089, 10'h1F6, 10'h300, 10'h006, 10'h118};
    logic [7:0] lit;
    foreach (tbl[k])
    begin
      v <= tbl[k];
      idle(8);
      lit = {v[7:5], v[4] & (v[8] | !v[3]), v[2] & v[8], v[7] & !v[8] & !v[0],
        v[8] ? v[1] : v[3], v[8]};
      // Inverted inside a concatenation so the upper byte stays zero
      cmp("leds", {8'h00, ~lit}, led);
      cmp("port", v[9] | !v[8], nibblePortSel);
    end
  endtask : t_leds
  task automatic t_gpio;
    wr(REG_VENDOR, 16'h0500);
    drv <= 2'h2;
    val <= 2'h2;
    idle(8);
    cmp("pins", 16'h0016, {oe, o, pd});
    rd(REG_VENDOR, d);
    cmp("lvl", 16'h0780, d & 16'h0FC0);
    wr(REG_VENDOR, 16'h02C0);
    drv <= 2'h0;
    idle(8);
    cmp("pins", 16'h0021, {oe, o, pd});
    rd(REG_VENDOR, d);
    cmp("lvl", 16'h0040, d & 16'h0FC0);
  endtask : t_gpio
  task automatic t_irq;
    wr(REG_IRQ_CTRL, 16'h0100);
    pulse(8'h02, 8'h00);
    cmp("irqoff", 16'h0000, irqOe);
    pulse(8'h01, 8'h00);
    cmp("irqon", 16'h0002, {irqOe, irqWire});
    rd(REG_EVENTS, d);
    cmp("events", 16'h0003, d);
    idle(3);
    cmp("irqrel", 16'h0000, irqOe);
    wr(REG_VENDOR, 16'h4141);
    wr(REG_PHONE_IRQ, 16'h0200);
    pulse(8'h00, 8'h02);
    cmp("irqhi", 16'h0003, {irqOe, irqWire});
    rd(REG_EVENTS, d);
    cmp("events", 16'h0200, d);
    wr(5'h05, 16'hFFFF);
    rd(5'h05, d);
    cmp("unmap", 16'h0000, d);
  endtask : t_irq
  initial
  begin
    idle(16);
    t_reset;
    t_strap;
    t_leds;
    t_gpio;
    t_irq;
    report_and_stop;
  end
  // Whole run is under a thousand cycles
  initial
  begin
    #(25 * 5000);
    failures++;
    report_and_stop;
  end
endmodule : testbench
